// ==== pm_wake_checker.sv ====
// assertion checker for the power state and wake pattern block
`timescale 1ns/1ps
`default_nettype none
module pm_wake_checker (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_dma_done,
  input wire logic        rx_dma_priority,
  input wire logic        rx_dma_irq,
  input wire logic        wake_signal_n,
  input wire logic        io_access_en,
  input wire logic        mem_access_en,
  input wire logic        bus_master_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic setup;
  logic commit;
  // setup phase and committed write, shared by the properties below
  assign setup  = psel & ~penable;
  assign commit = psel & penable & pwrite & pready & ~pslverr;

  a_reset_quiet: assert property ($fell(srst) |-> wake_signal_n
    && !io_access_en && !mem_access_en && !bus_master_en)
    else $error("outputs not idle after reset");
  a_ready_next: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property (pready |-> $past(setup))
    else $error("answer without setup");
  a_bad_addr: assert property (setup && !(paddr inside
    {32'h0, 32'h4, 32'h8, 32'hC, 32'h10}) |=> pslverr)
    else $error("unmapped address not refused");
  a_d0_no_wake: assert property (commit && paddr == 32'h0
    && pwdata[1:0] == 2'h0 |-> ##2 wake_signal_n)
    else $error("wake asserted after return to D0");
  a_d3_silent: assert property (commit && paddr == 32'h0
    && pwdata[1:0] == 2'h3 |-> ##2 !io_access_en && !mem_access_en
    && !bus_master_en)
    else $error("access enabled in D3");
  a_master_awake: assert property (bus_master_en |-> wake_signal_n)
    else $error("wake while master enabled");
  a_prio_irq: assert property (rx_dma_done && rx_dma_priority
    |=> rx_dma_irq)
    else $error("priority frame not interrupting");
endmodule : pm_wake_checker

bind power_state_wake_pattern_match pm_wake_checker u_chk (.clock, .srst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .rx_dma_done, .rx_dma_priority, .rx_dma_irq, .wake_signal_n,
  .io_access_en, .mem_access_en, .bus_master_en);
`default_nettype wire

// ==== power_state_wake_pattern_match.sv ====
// power state machine, wake event unit and wake pattern matcher
`include "wake_pm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_pattern_match #(
  parameter int PAT_DEPTH   = 64,
  parameter int FRAME_DEPTH = 128
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] eeprom_config_word,
  input  wire logic        tx_path_reset,
  input  wire logic        pat_wr_valid,
  input  wire logic [7:0]  pat_wr_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_filter_pass,
  input  wire logic        special_frame_event,
  input  wire logic        link_up,
  input  wire logic        rx_dma_done,
  input  wire logic        rx_dma_priority,
  output logic             wake_signal_n,
  output logic             io_access_en,
  output logic             mem_access_en,
  output logic             bus_master_en,
  output logic             rx_dma_irq
);
  localparam int PW = $clog2(PAT_DEPTH + 1);
  localparam int FW = $clog2(FRAME_DEPTH + 1);
  localparam int D2_EXIT_CYC =
    (`D2_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // refuse sizes the pointers and the crc tail cannot serve
  if (PAT_DEPTH < 5 || PAT_DEPTH > 65535) begin : g_bad_pat
    $error("PAT_DEPTH out of range");
  end
  if (FRAME_DEPTH < 16 || FRAME_DEPTH > 65535) begin : g_bad_frame
    $error("FRAME_DEPTH out of range");
  end

  typedef struct packed {
    wake_pm_pkg::pwr_t                 pwr;
    logic [7:0]                        exit_cnt;
    logic [2:0]                        cmd;
    logic [3:0]                        wk_en;
    logic [2:0]                        wk_flg;
    logic                              link_ref;
    logic [7:0]                        coal_th;
    logic [7:0]                        coal_cnt;
    logic                              irq;
    logic                              wake_n;
    logic                              io_en;
    logic                              mem_en;
    logic                              bm_en;
    logic [31:0]                       rdata;
    logic                              rdy;
    logic                              err;
    logic [PAT_DEPTH-1:0][7:0]         pmem;
    logic [PW-1:0]                     pcnt;
    logic [PW-1:0]                     pp;
    logic [FRAME_DEPTH-1:0][7:0]       fbuf;
    logic [FW-1:0]                     flen;
    logic [15:0]                       fp;
    logic [7:0]                        len;
    logic                              len_ext;
    logic [31:0]                       crc;
    logic [31:0]                       cmp;
    logic [1:0]                        cidx;
    logic                              bad;
    logic                              hit;
    wake_pm_pkg::match_t               m;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // one byte of the reflected ethernet fcs crc
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // any of the three sleep states
  function automatic logic asleep(input wake_pm_pkg::pwr_t p);
    return p == wake_pm_pkg::PW_D1 || p == wake_pm_pkg::PW_D2 ||
           p == wake_pm_pkg::PW_D3;
  endfunction : asleep

  function automatic logic [1:0] ps_code(input wake_pm_pkg::pwr_t p);
    case (p)
      wake_pm_pkg::PW_D1: ps_code = `PS_D1;
      wake_pm_pkg::PW_D2: ps_code = `PS_D2;
      wake_pm_pkg::PW_D3: ps_code = `PS_D3;
      default:            ps_code = `PS_D0;
    endcase
  endfunction : ps_code

  function automatic logic mapped(input logic [31:0] a);
    return a == 32'(`OFF_PM) || a == 32'(`OFF_CMD) ||
           a == 32'(`OFF_WAKE) || a == 32'(`OFF_COAL) ||
           a == 32'(`OFF_STAT);
  endfunction : mapped

  always_comb begin
    logic        wr;
    logic [7:0]  b;
    logic [2:0]  set;
    logic [2:0]  clr;
    logic        d1_ok;
    logic        d2_ok;
    wr     = 1'b0;
    b      = 8'h00;
    set    = 3'b000;
    clr    = 3'b000;
    d1_ok  = eeprom_config_word[`EE_D1_BIT];
    d2_ok  = eeprom_config_word[`EE_D2_BIT];
    st_nxt = st_r;

    // apb: setup cycle loads the answer, access edge commits the write
    st_nxt.rdy = psel && !penable;
    st_nxt.err = psel && !penable && !mapped(paddr);
    st_nxt.rdata = 32'h00000000;
    if (psel && !penable) begin
      case (paddr[7:0])
        `OFF_PM:   st_nxt.rdata = {30'h00000000, ps_code(st_r.pwr)};
        `OFF_CMD:  st_nxt.rdata = {29'h00000000, st_r.cmd};
        `OFF_WAKE: st_nxt.rdata = {21'h000000, st_r.wk_flg, 4'h0,
                                   st_r.wk_en};
        `OFF_COAL: st_nxt.rdata = {24'h000000, st_r.coal_th};
        `OFF_STAT: begin
          st_nxt.rdata[4:0] = st_r.pwr;
          st_nxt.rdata[`ST_BUSY_BIT] = st_r.m != wake_pm_pkg::M_IDLE;
          st_nxt.rdata[`ST_D1_BIT] = d1_ok;
          st_nxt.rdata[`ST_D2_BIT] = d2_ok;
          st_nxt.rdata[`ST_PCNT_LSB +: PW] = st_r.pcnt;
        end
        default:   st_nxt.rdata = 32'h00000000;
      endcase
    end
    wr = psel && penable && st_r.rdy && pwrite && !st_r.err;

    // power state moves; config stays reachable in every state
    if (st_r.exit_cnt != 8'h00) begin
      st_nxt.exit_cnt = st_r.exit_cnt - 8'h01;
      if (st_r.exit_cnt == 8'h01) begin
        st_nxt.pwr = wake_pm_pkg::PW_D0A;
      end
    end else if (wr && paddr[7:0] == `OFF_PM) begin
      case (pwdata[1:0])
        `PS_D0: begin
          if (st_r.pwr == wake_pm_pkg::PW_D1) begin
            st_nxt.pwr = wake_pm_pkg::PW_D0A;
          end else if (st_r.pwr == wake_pm_pkg::PW_D2) begin
            st_nxt.exit_cnt = 8'(D2_EXIT_CYC);
          end else if (st_r.pwr == wake_pm_pkg::PW_D3) begin
            st_nxt.pwr = wake_pm_pkg::PW_D0U;
            st_nxt.cmd = 3'b000;
          end
        end
        `PS_D1: if (d1_ok && st_r.pwr != wake_pm_pkg::PW_D3) begin
          st_nxt.pwr = wake_pm_pkg::PW_D1;
        end
        `PS_D2: if (d2_ok && st_r.pwr != wake_pm_pkg::PW_D3) begin
          st_nxt.pwr = wake_pm_pkg::PW_D2;
        end
        default: st_nxt.pwr = wake_pm_pkg::PW_D3;
      endcase
    end
    if (wr && paddr[7:0] == `OFF_CMD) begin
      st_nxt.cmd = pwdata[2:0];
    end
    // all three enables written means software has initialised us
    if (st_r.pwr == wake_pm_pkg::PW_D0U && &st_r.cmd) begin
      st_nxt.pwr = wake_pm_pkg::PW_D0A;
    end

    // cycle gating: D0U config only, D2 and D3 refuse io and memory
    st_nxt.io_en  = (st_r.pwr == wake_pm_pkg::PW_D0A ||
                     st_r.pwr == wake_pm_pkg::PW_D1) &&
                    st_r.cmd[`CMD_IO];
    st_nxt.mem_en = (st_r.pwr == wake_pm_pkg::PW_D0A ||
                     st_r.pwr == wake_pm_pkg::PW_D1) &&
                    st_r.cmd[`CMD_MEM];
    st_nxt.bm_en  = st_r.pwr == wake_pm_pkg::PW_D0A &&
                    st_r.cmd[`CMD_BM];

    // wake control: enables, link reference taken when enabled
    if (wr && paddr[7:0] == `OFF_WAKE) begin
      st_nxt.wk_en = pwdata[3:0];
      clr = pwdata[`WK_FLG_LSB +: 3];
      if (pwdata[`WK_LNK_EN] && !st_r.wk_en[`WK_LNK_EN]) begin
        st_nxt.link_ref = link_up;
      end
    end
    set[`WK_SPC_EN] = special_frame_event && asleep(st_r.pwr) &&
                      st_r.wk_en[`WK_SPC_EN];
    set[`WK_LNK_EN] = link_up != st_r.link_ref && asleep(st_r.pwr) &&
                      st_r.wk_en[`WK_LNK_EN];
    set[`WK_PAT_EN] = st_r.m == wake_pm_pkg::M_DONE && st_r.hit &&
                      asleep(st_r.pwr) &&
                      st_r.wk_en[`WK_PAT_EN];
    // a set in the clearing cycle survives the write-one-to-clear
    st_nxt.wk_flg = (st_r.wk_flg & ~clr) | set;
    st_nxt.wake_n = !(asleep(st_r.pwr) && st_r.exit_cnt == 8'h00 &&
                      st_r.wk_en[`WK_SIG_EN] &&
                      |(st_nxt.wk_flg & st_r.wk_en[2:0]));

    // receive coalescing: priority frames bypass the count
    st_nxt.irq = 1'b0;
    if (wr && paddr[7:0] == `OFF_COAL) begin
      st_nxt.coal_th = pwdata[7:0];
    end
    if (rx_dma_done && rx_dma_priority) begin
      st_nxt.irq = 1'b1;
    end else if (rx_dma_done) begin
      if (st_r.coal_cnt + 8'h01 >= st_r.coal_th) begin
        st_nxt.irq      = 1'b1;
        st_nxt.coal_cnt = 8'h00;
      end else begin
        st_nxt.coal_cnt = st_r.coal_cnt + 8'h01;
      end
    end

    // pattern block arrives as a byte stream; tx reset empties it
    if (tx_path_reset) begin
      st_nxt.pcnt = '0;
    end else if (pat_wr_valid && st_r.pcnt < PW'(PAT_DEPTH) &&
                 st_r.m == wake_pm_pkg::M_IDLE) begin
      st_nxt.pmem[st_r.pcnt] = pat_wr_data;
      st_nxt.pcnt = st_r.pcnt + PW'(1);
    end

    // matcher: capture a frame, then walk every stored pattern
    b = st_r.pmem[st_r.pp];
    case (st_r.m)
      wake_pm_pkg::M_IDLE: begin
        if (rx_valid && rx_sof && asleep(st_r.pwr)) begin
          st_nxt.fbuf[0] = rx_data;
          st_nxt.flen = FW'(1);
          st_nxt.m = rx_eof ? wake_pm_pkg::M_IDLE : wake_pm_pkg::M_CAPT;
        end
      end
      wake_pm_pkg::M_CAPT: begin
        if (rx_valid && st_r.flen < FW'(FRAME_DEPTH)) begin
          st_nxt.fbuf[st_r.flen] = rx_data;
          st_nxt.flen = st_r.flen + FW'(1);
        end
        if (rx_valid && rx_eof) begin
          st_nxt.pp = '0;
          st_nxt.fp = 16'h0000;
          st_nxt.crc = `CRC_INIT;
          st_nxt.bad = 1'b0;
          st_nxt.hit = 1'b0;
          st_nxt.m = (rx_filter_pass && st_r.pcnt != '0) ?
                     wake_pm_pkg::M_WALK :
                     wake_pm_pkg::M_IDLE;
        end
      end
      wake_pm_pkg::M_WALK: begin
        if (st_r.pp >= st_r.pcnt) begin
          st_nxt.m = wake_pm_pkg::M_DONE;
        end else begin
          st_nxt.pp = st_r.pp + PW'(1);
          st_nxt.len = {4'h0, b[3:0]};
          st_nxt.len_ext = b[3:0] == `NIB_ESC;
          if (b == `PAT_END) begin
            st_nxt.cidx = 2'h0;
            st_nxt.m = wake_pm_pkg::M_CRC;
          end else if (b[7:4] == `NIB_ESC) begin
            st_nxt.m = wake_pm_pkg::M_XOFF;
          end else begin
            st_nxt.fp = st_r.fp + {12'h000, b[7:4]};
            st_nxt.m = (b[3:0] == `NIB_ESC) ? wake_pm_pkg::M_XLEN :
                       wake_pm_pkg::M_SEL;
          end
        end
      end
      wake_pm_pkg::M_XOFF: begin
        st_nxt.pp = st_r.pp + PW'(1);
        st_nxt.fp = st_r.fp + {8'h00, b};
        st_nxt.m = st_r.len_ext ? wake_pm_pkg::M_XLEN :
                   wake_pm_pkg::M_SEL;
        if (st_r.pp >= st_r.pcnt) begin
          st_nxt.m = wake_pm_pkg::M_DONE;
        end
      end
      wake_pm_pkg::M_XLEN: begin
        st_nxt.pp = st_r.pp + PW'(1);
        st_nxt.len = b;
        st_nxt.m = (st_r.pp >= st_r.pcnt) ? wake_pm_pkg::M_DONE :
                   wake_pm_pkg::M_SEL;
      end
      wake_pm_pkg::M_SEL: begin
        if (st_r.len == 8'h00) begin
          st_nxt.m = wake_pm_pkg::M_WALK;
        end else begin
          // bytes past the captured frame can never match
          if (st_r.fp >= 16'(st_r.flen)) begin
            st_nxt.bad = 1'b1;
          end else begin
            st_nxt.crc = crc_byte(st_r.crc,
                                  st_r.fbuf[st_r.fp[FW-1:0]]);
          end
          st_nxt.fp = st_r.fp + 16'h0001;
          st_nxt.len = st_r.len - 8'h01;
        end
      end
      wake_pm_pkg::M_CRC: begin
        if (st_r.pp >= st_r.pcnt) begin
          st_nxt.m = wake_pm_pkg::M_DONE;
        end else begin
          st_nxt.pp = st_r.pp + PW'(1);
          st_nxt.cmp[st_r.cidx*8 +: 8] = b;
          st_nxt.cidx = st_r.cidx + 2'h1;
          if (st_r.cidx == 2'h3) begin
            // a crc alias also wakes; that is accepted
            if (!st_r.bad && ~st_r.crc == {b, st_r.cmp[23:0]}) begin
              st_nxt.hit = 1'b1;
            end
            st_nxt.fp = 16'h0000;
            st_nxt.crc = `CRC_INIT;
            st_nxt.bad = 1'b0;
            st_nxt.m = wake_pm_pkg::M_WALK;
          end
        end
      end
      wake_pm_pkg::M_DONE: st_nxt.m = wake_pm_pkg::M_IDLE;
      default:             st_nxt.m = wake_pm_pkg::M_IDLE;
    endcase
    if (tx_path_reset) begin
      st_nxt.m = wake_pm_pkg::M_IDLE;
    end
  end

  // single state register; reset lands in D0 uninitialized
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r          <= '0;
      st_r.pwr      <= wake_pm_pkg::PW_D0U;
      st_r.m        <= wake_pm_pkg::M_IDLE;
      st_r.wake_n   <= 1'b1;
      st_r.coal_th  <= `COAL_RST;
      st_r.crc      <= `CRC_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata        = st_r.rdata;
  assign pready        = st_r.rdy;
  assign pslverr       = st_r.err;
  assign wake_signal_n = st_r.wake_n;
  assign io_access_en  = st_r.io_en;
  assign mem_access_en = st_r.mem_en;
  assign bus_master_en = st_r.bm_en;
  assign rx_dma_irq    = st_r.irq;
endmodule : power_state_wake_pattern_match
`default_nettype wire

// ==== rx_frame_source.sv ====
// receive side model: sends frames whose byte i is 8'hA0 xor i
`timescale 1ns/1ps
`default_nettype none
module rx_frame_source (
  input wire logic        clock,
  input wire logic        start,
  input wire logic [7:0]  len,
  input wire logic        pass,
  output logic            rx_valid,
  output logic            rx_sof,
  output logic            rx_eof,
  output logic     [7:0]  rx_data,
  output logic            rx_filter_pass,
  output logic            busy
);
  logic [7:0] idx_r = 8'h00;
  logic       last;
  initial begin
    {rx_valid, rx_sof, rx_eof, busy, rx_filter_pass} = 5'h00;
    rx_data = 8'h00;
  end
  assign last = (idx_r == 8'(len - 8'h01));
  // idle data toggles so a stale byte never looks valid
  always @(posedge clock) begin
    if (busy) begin
      rx_valid       <= 1'h1;
      rx_sof         <= (idx_r == 8'h00);
      rx_eof         <= last;
      rx_data        <= 8'hA0 ^ idx_r;
      rx_filter_pass <= last ? pass : ~pass;
      idx_r          <= idx_r + 8'h01;
      busy           <= !last;
    end else begin
      rx_valid       <= 1'h0;
      rx_sof         <= 1'h0;
      rx_eof         <= 1'h0;
      rx_data        <= ~rx_data;
      rx_filter_pass <= ~pass;
      idx_r          <= 8'h00;
      busy           <= start;
    end
  end
endmodule : rx_frame_source
`default_nettype wire

// ==== test_power_state_wake_pattern_match.sv ====
// self-checking testbench for the power state and wake pattern block
`include "wake_pm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_power_state_wake_pattern_match;
  logic        clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, pready, pslverr, e;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [15:0] eeprom_config_word = 16'h0;
  logic        tx_path_reset = 1'h0, pat_wr_valid = 1'h0;
  logic [7:0]  pat_wr_data = 8'h00, rx_data, len = 8'h00;
  logic        rx_valid, rx_sof, rx_eof, rx_filter_pass, busy;
  logic        start = 1'h0, pass = 1'h0, special_frame_event = 1'h0;
  logic        link_up = 1'h0, rx_dma_done = 1'h0, rx_dma_priority = 1'h0;
  logic        wake_signal_n, io_access_en, mem_access_en;
  logic        bus_master_en, rx_dma_irq;
  int          fails = 0, checks_done = 0, irqs = 0;

  power_state_wake_pattern_match dut (.clock, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .eeprom_config_word, .tx_path_reset, .pat_wr_valid, .pat_wr_data,
    .rx_valid, .rx_sof, .rx_eof, .rx_data, .rx_filter_pass,
    .special_frame_event, .link_up, .rx_dma_done, .rx_dma_priority,
    .wake_signal_n, .io_access_en, .mem_access_en, .bus_master_en,
    .rx_dma_irq);
  rx_frame_source mac (.clock, .start, .len, .pass, .rx_valid, .rx_sof,
    .rx_eof, .rx_data, .rx_filter_pass, .busy);

  initial begin
    forever #5 clock = ~clock;
  end
  // interrupt pulses are counted so coalescing can be judged later
  always @(posedge clock) begin
    if (rx_dma_irq === 1'h1) irqs++;
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    // no wait limit here: the watchdog ends a hung transfer
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r & m, x);
  endtask : rd

  task settle();
    repeat (3) @(posedge clock);
  endtask : settle

  function automatic logic [31:0] en3();
    return {29'h0, io_access_en, mem_access_en, bus_master_en};
  endfunction : en3

  task wait_wake(input logic x);
    int n;
    n = 0;
    while (wake_signal_n !== 1'h0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, wake_signal_n}, {31'h0, x});
  endtask : wait_wake

  task send(input logic [7:0] l, input logic p);
    @(posedge clock);
    len   <= l;
    pass  <= p;
    start <= 1'h1;
    @(posedge clock);
    start <= 1'h0;
    @(posedge clock);
    // a stuck source is left to the watchdog, which counts it
    while (busy === 1'h1) begin
      @(posedge clock);
    end
  endtask : send

  task pulse(input logic p, input logic sp);
    @(posedge clock);
    rx_dma_done         <= !sp;
    rx_dma_priority     <= p;
    special_frame_event <= sp;
    @(posedge clock);
    rx_dma_done         <= 1'h0;
    special_frame_event <= 1'h0;
  endtask : pulse

  // reference crc over frame bytes 1, 2 and 19..34
  function automatic logic [31:0] crc_sel();
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < 40; i++) begin
      if (i == 1 || i == 2 || (i >= 19 && i <= 34)) begin
        c = c ^ {24'h0, 8'hA0 ^ 8'(i)};
        repeat (8) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc_sel

  task t_reset();
    chk({31'h0, wake_signal_n}, 32'h1);
    chk(en3(), 32'h0);
    rd(`OFF_STAT, 32'h1F, 32'h1);
    wr(`OFF_STAT, 32'h1F);
    rd(`OFF_STAT, 32'h1F, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
  endtask : t_reset

  task t_power();
    wr(`OFF_WAKE, 32'h9);
    wr(`OFF_CMD, 32'h7);
    settle();
    rd(`OFF_STAT, 32'h1F, 32'h2);
    chk(en3(), 32'h7);
    chk({31'h0, wake_signal_n}, 32'h1);
    wr(`OFF_PM, 32'h1);
    rd(`OFF_STAT, 32'h1F, 32'h2);
    eeprom_config_word <= 16'h0001;
    wr(`OFF_PM, 32'h1);
    settle();
    rd(`OFF_STAT, 32'h1F, 32'h4);
    chk(en3(), 32'h6);
    wr(`OFF_PM, 32'h0);
    rd(`OFF_STAT, 32'h1F, 32'h2);
    wr(`OFF_PM, 32'h2);
    rd(`OFF_STAT, 32'h1F, 32'h2);
    eeprom_config_word <= 16'h0003;
    wr(`OFF_PM, 32'h2);
    settle();
    rd(`OFF_STAT, 32'h1F, 32'h8);
    chk(en3(), 32'h0);
    wr(`OFF_PM, 32'h0);
    rd(`OFF_STAT, 32'h1F, 32'h8);
    repeat (12) @(posedge clock);
    rd(`OFF_STAT, 32'h1F, 32'h2);
    wr(`OFF_PM, 32'h3);
    settle();
    rd(`OFF_STAT, 32'h1F, 32'h10);
    chk(en3(), 32'h0);
    rd(`OFF_PM, 32'h3, 32'h3);
    wr(`OFF_PM, 32'h0);
    settle();
    rd(`OFF_STAT, 32'h1F, 32'h1);
    rd(`OFF_CMD, 32'h7, 32'h0);
    $display("power state test done");
  endtask : t_power

  task t_pattern();
    logic [31:0] c;
    logic [31:0] w;
    logic [7:0]  pat[$];
    c = crc_sel();
    w = c ^ 32'h1;
    pat = {8'h21, 8'h00, w[7:0], w[15:8], w[23:16], w[31:24],
           8'h12, 8'hFF, 8'h10, 8'h10, 8'h00,
           c[7:0], c[15:8], c[23:16], c[31:24]};
    @(posedge clock);
    tx_path_reset <= 1'h1;
    @(posedge clock);
    tx_path_reset <= 1'h0;
    // unaligned bytes, as fetched through the list pointer
    foreach (pat[i]) begin
      pat_wr_valid <= 1'h1;
      pat_wr_data  <= pat[i];
      @(posedge clock);
    end
    pat_wr_valid <= 1'h0;
    rd(`OFF_STAT, 32'hFFFF0000, 32'h000F0000);
    wr(`OFF_PM, 32'h3);
    wr(`OFF_WAKE, 32'h8);
    send(8'h28, 1'h1);
    wait_wake(1'h1);
    wr(`OFF_WAKE, 32'h9);
    send(8'h28, 1'h0);
    wait_wake(1'h1);
    send(8'h28, 1'h1);
    wait_wake(1'h0);
    rd(`OFF_WAKE, 32'h70F, 32'h109);
    wr(`OFF_WAKE, 32'h109);
    rd(`OFF_WAKE, 32'h70F, 32'h9);
    wr(`OFF_PM, 32'h0);
    settle();
    chk({31'h0, wake_signal_n}, 32'h1);
    $display("pattern test done");
  endtask : t_pattern

  task t_sources();
    wr(`OFF_PM, 32'h3);
    wr(`OFF_WAKE, 32'h70A);
    pulse(1'h0, 1'h1);
    wait_wake(1'h0);
    rd(`OFF_WAKE, 32'h700, 32'h200);
    wr(`OFF_WAKE, 32'h70C);
    pulse(1'h0, 1'h1);
    wait_wake(1'h1);
    link_up <= 1'h1;
    wait_wake(1'h0);
    rd(`OFF_WAKE, 32'h700, 32'h400);
    wr(`OFF_PM, 32'h0);
    settle();
    chk({31'h0, wake_signal_n}, 32'h1);
    $display("wake source test done");
  endtask : t_sources

  task t_coal();
    wr(`OFF_COAL, 32'h3);
    pulse(1'h0, 1'h0);
    pulse(1'h0, 1'h0);
    settle();
    chk(32'(irqs), 32'h0);
    pulse(1'h0, 1'h0);
    settle();
    chk(32'(irqs), 32'h1);
    pulse(1'h1, 1'h0);
    settle();
    chk(32'(irqs), 32'h2);
    $display("coalescing test done");
  endtask : t_coal

  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    t_reset();
    t_power();
    t_pattern();
    t_sources();
    t_coal();
    wrap_up();
  end
  // the tests need a little under a thousand cycles; give them ample slack
  initial begin
    #300000;
    fails++;
    wrap_up();
  end
endmodule : test_power_state_wake_pattern_match
`default_nettype wire

// ==== wake_pm_cfg.svh ====
// constants for the power state and wake pattern block
`ifndef WAKE_PM_CFG_SVH
`define WAKE_PM_CFG_SVH
`define OFF_PM        8'h00
`define OFF_CMD       8'h04
`define OFF_WAKE      8'h08
`define OFF_COAL      8'h0C
`define OFF_STAT      8'h10
`define PS_D0         2'h0
`define PS_D1         2'h1
`define PS_D2         2'h2
`define PS_D3         2'h3
`define CMD_IO        0
`define CMD_MEM       1
`define CMD_BM        2
`define WK_PAT_EN     0
`define WK_SPC_EN     1
`define WK_LNK_EN     2
`define WK_SIG_EN     3
`define WK_FLG_LSB    8
`define EE_D1_BIT     0
`define EE_D2_BIT     1
`define ST_BUSY_BIT   5
`define ST_D1_BIT     6
`define ST_D2_BIT     7
`define ST_PCNT_LSB   16
`define COAL_RST      8'h01
`define NIB_ESC       4'hF
`define PAT_END       8'h00
`define CRC_INIT      32'hFFFFFFFF
`define CRC_POLY      32'hEDB88320
`define CLK_PERIOD_NS 10
`define D2_EXIT_NS    100
`endif

// ==== wake_pm_pkg.sv ====
// types shared by the power state and wake pattern block
package wake_pm_pkg;
  typedef enum logic [4:0] {
    PW_D0U = 5'h01,
    PW_D0A = 5'h02,
    PW_D1  = 5'h04,
    PW_D2  = 5'h08,
    PW_D3  = 5'h10
  } pwr_t;
  typedef enum logic [7:0] {
    M_IDLE = 8'h01,
    M_CAPT = 8'h02,
    M_WALK = 8'h04,
    M_XOFF = 8'h08,
    M_XLEN = 8'h10,
    M_SEL  = 8'h20,
    M_CRC  = 8'h40,
    M_DONE = 8'h80
  } match_t;
endpackage : wake_pm_pkg
